// File: verilog/aseq_pkg.sv
// Constants, register map and types of the conversion sequencer
package aseq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register port
	localparam int         ADDR_W = 4;
	localparam int         DATA_W = 8;

	localparam logic [3:0] OFS_CTRL0 = 4'h0;
	localparam logic [3:0] OFS_CTRL1 = 4'h1;
	localparam logic [3:0] OFS_TRIG  = 4'h2;
	localparam logic [3:0] OFS_STAT  = 4'h3;

	localparam logic [7:0] RST_CTRL0 = 8'h00;
	localparam logic [7:0] RST_CTRL1 = 8'h00;
	localparam logic [7:0] RST_TRIG  = 8'h00;
	localparam logic [7:0] RST_STAT  = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field layouts
	localparam int         CTRL0_ON_BIT  = 0;
	localparam int         CTRL0_GO_BIT  = 1;
	localparam int         CTRL0_CHS_LSB = 2;
	localparam int         CHS_W         = 6;
	localparam int         CTRL1_CS_LSB  = 4;
	localparam int         CS_W          = 3;
	localparam logic [2:0] CS_RC_MASK    = 3'h3;
	localparam int         TRIG_W        = 5;
	localparam int         STAT_FLAG_BIT = 0;
	localparam int         STAT_IE_BIT   = 1;
	localparam int         STAT_PWR_BIT  = 2;
	localparam int         STAT_BUSY_BIT = 3;
	localparam int         STAT_SOFF_BIT = 4;

	////////////////////////////////////////////////////////////////////////////
	// Trigger select codes
	localparam logic [4:0] TRIG_OFF   = 5'h00;
	localparam logic [4:0] TRIG_LAST  = 5'h12;
	localparam int         TRIG_SRC_N = 19;

	////////////////////////////////////////////////////////////////////////////
	// Channel codes
	localparam logic [5:0] CH_REF2       = 6'h3f;
	localparam logic [5:0] CH_REF1       = 6'h3e;
	localparam logic [5:0] CH_DAC        = 6'h3d;
	localparam logic [5:0] CH_TEMP       = 6'h3c;
	localparam logic [5:0] CH_GND        = 6'h3b;
	localparam logic [5:0] CH_PORTD_LAST = 6'h1f;
	localparam logic [5:0] CH_E_BASE     = 6'h20;
	localparam logic [5:0] CH_E_LAST     = 6'h22;
	localparam logic [5:0] CH_F_BASE     = 6'h28;
	localparam logic [5:0] CH_F_LAST     = 6'h2f;
	localparam logic [5:0] CH_A6         = 6'h06;
	localparam logic [5:0] CH_A7         = 6'h07;
	localparam int         PORT_W        = 3;
	localparam int         PIN_W         = 3;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		SRC_NONE, SRC_PIN, SRC_REF2, SRC_REF1, SRC_DAC, SRC_TEMP, SRC_GND
	} aseq_src_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_DELAY, ST_CONV
	} aseq_state_t;

endpackage : aseq_pkg

// File: verilog/aseq_link_if.sv
// Internal carrier between the sequencer core and its trigger and channel units
interface aseq_link_if;
	import aseq_pkg::*;

	logic [TRIG_W-1:0] trig_sel;
	logic              trig_edge;
	logic [CHS_W-1:0]  chan_code;
	logic              ext_clk_sel;
	aseq_src_t         chan_src;
	logic [PORT_W-1:0] chan_port;
	logic [PIN_W-1:0]  chan_pin;

	modport core (
		output trig_sel, chan_code, ext_clk_sel,
		input  trig_edge, chan_src, chan_port, chan_pin
	);
	modport trig (
		input  trig_sel,
		output trig_edge
	);
	modport chan (
		input  chan_code, ext_clk_sel,
		output chan_src, chan_port, chan_pin
	);

endinterface : aseq_link_if

// File: verilog/aseq_trig_sel.sv
// Auto-trigger source selection and rising-edge detection
module aseq_trig_sel
	import aseq_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Trigger sources, bit n belongs to select value n
	input  wire logic [TRIG_SRC_N-1:0] trig_src,
	input  wire logic                  sleep_active,
	// Core side
	aseq_link_if.trig                  lnk
);

	logic [TRIG_SRC_N-1:0] hit;
	logic                  level;
	logic                  level_q;
	logic                  level_d;
	logic                  edge_q;
	logic                  edge_d;

	////////////////////////////////////////////////////////////////////////////
	// Select value 0 means no trigger; reserved codes match no index
	assign hit[0] = 1'b0;
	generate
		for (genvar i = 1; i < TRIG_SRC_N; i++) begin : g_hit
			assign hit[i] = (lnk.trig_sel == TRIG_W'(i)) && trig_src[i];
		end
	endgenerate

	assign level = |hit;

	////////////////////////////////////////////////////////////////////////////
	// Level tracks on in sleep so no stale edge fires at wake-up
	always_comb begin
		level_d = level;
		edge_d  = level && !level_q && !sleep_active;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_q <= 1'b0;
			edge_q  <= 1'b0;
		end else begin
			level_q <= level_d;
			edge_q  <= edge_d;
		end
	end

	assign lnk.trig_edge = edge_q;

endmodule : aseq_trig_sel

// File: verilog/aseq_chan_dec.sv
// Analog channel code decoder for the sample-and-hold input mux
module aseq_chan_dec
	import aseq_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Core side
	aseq_link_if.chan lnk
);

	aseq_src_t         src_d;
	aseq_src_t         src_q;
	logic [PORT_W-1:0] port_d;
	logic [PORT_W-1:0] port_q;
	logic [PIN_W-1:0]  pin_d;
	logic [PIN_W-1:0]  pin_q;
	logic [CHS_W-1:0]  code;

	assign code = lnk.chan_code;

	////////////////////////////////////////////////////////////////////////////
	// Port number is code[5:3]; pin number is code[2:0]
	always_comb begin
		src_d  = SRC_NONE;
		port_d = '0;
		pin_d  = '0;
		if (code == CH_REF2) begin
			src_d = SRC_REF2;
		end else if (code == CH_REF1) begin
			src_d = SRC_REF1;
		end else if (code == CH_DAC) begin
			src_d = SRC_DAC;
		end else if (code == CH_TEMP) begin
			src_d = SRC_TEMP;
		end else if (code == CH_GND) begin
			src_d = SRC_GND;
		end else if (code <= CH_PORTD_LAST) begin
			// External clock pins lose their analog function
			if (!(lnk.ext_clk_sel && (code == CH_A6 || code == CH_A7))) begin
				src_d  = SRC_PIN;
				port_d = code[CHS_W-1:PIN_W];
				pin_d  = code[PIN_W-1:0];
			end
		end else if ((code >= CH_E_BASE && code <= CH_E_LAST) ||
		             (code >= CH_F_BASE && code <= CH_F_LAST)) begin
			src_d  = SRC_PIN;
			port_d = code[CHS_W-1:PIN_W];
			pin_d  = code[PIN_W-1:0];
		end
		// Anything else stays unconnected
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			src_q  <= SRC_NONE;
			port_q <= '0;
			pin_q  <= '0;
		end else begin
			src_q  <= src_d;
			port_q <= port_d;
			pin_q  <= pin_d;
		end
	end

	assign lnk.chan_src  = src_q;
	assign lnk.chan_port = port_q;
	assign lnk.chan_pin  = pin_q;

endmodule : aseq_chan_dec

// File: verilog/aseq_top.sv
// Conversion sequencer: registers, start control, sleep handling
//
// Operation
// - Conversions continue through sleep only with the dedicated RC clock.
// - RC clock delays conversion start by one instruction cycle.
// - Completion in sleep with interrupt enabled wakes the device.
// - Completion in sleep, interrupt disabled: converter powers down, enable reads set.
// - Sleep with a non-RC clock aborts conversion and powers down, enable kept.
// - Rising edge of selected trigger sets the go flag.
// - A 5-bit field selects the trigger source.
// - Triggers are ignored during sleep.
// - Select 0 disables triggering; 1 picks the mapped trigger pin.
// - Selects 2, 3, 4 pick timer zero, one overflow, timer two match.
// - Selects 5 to 0x12 pick capture, pulse, oscillator, comparator, change, logic.
// - Control register zero bits 7-2 hold the 6-bit channel select.
// - Top five channel codes select references, DAC, temperature sensor, ground.
// - Unassigned codes 0x23 to 0x27 and 0x30 to 0x3a connect nothing.
// - Port pins numbered eight per port from zero; E and F at fixed codes.
// - Writing go starts a conversion; hardware clears it at completion.
// - Bit 0 enables the converter; clear means off, no current.
// - Port A pins 6 and 7 lose analog function with external clock.
//
// Added by the designer: the register offsets and the strobed register port.
module aseq_top
	import aseq_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Register port
	input  wire logic [ADDR_W-1:0]     reg_addr,
	input  wire logic [DATA_W-1:0]     reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [DATA_W-1:0]     reg_rdata,
	// Core status
	input  wire logic                  sleep_active,
	input  wire logic                  instr_tick,
	input  wire logic                  ext_clk_sel,
	output logic                       wake_request,
	// Analog converter
	input  wire logic                  conv_done,
	output logic                       conv_start,
	output logic                       conv_abort,
	output logic                       analog_enable,
	output aseq_src_t                  chan_src,
	output logic      [PORT_W-1:0]     chan_port,
	output logic      [PIN_W-1:0]      chan_pin,
	// Trigger sources
	input  wire logic [TRIG_SRC_N-1:0] trig_src
);

	aseq_link_if lnk ();

	aseq_state_t       state_q;
	aseq_state_t       state_d;
	logic [CHS_W-1:0]  chs_q;
	logic [CHS_W-1:0]  chs_d;
	logic              on_q;
	logic              on_d;
	logic              go_q;
	logic              go_d;
	logic [CS_W-1:0]   cs_q;
	logic [CS_W-1:0]   cs_d;
	logic [TRIG_W-1:0] tsel_q;
	logic [TRIG_W-1:0] tsel_d;
	logic              flag_q;
	logic              flag_d;
	logic              ie_q;
	logic              ie_d;
	logic              soff_q;
	logic              soff_d;
	logic              start_q;
	logic              start_d;
	logic              abort_q;
	logic              abort_d;
	logic              wake_q;
	logic              wake_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;

	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_trig;
	logic wr_stat;
	logic rc_clk;
	logic sleep_kill;
	logic go_req;
	logic cancel;
	logic done_evt;

	////////////////////////////////////////////////////////////////////////////
	// Helper units
	aseq_trig_sel u_trig (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.trig_src     (trig_src),
		.sleep_active (sleep_active),
		.lnk          (lnk.trig)
	);

	aseq_chan_dec u_chan (
		.sys_clk (sys_clk),
		.rst     (rst),
		.lnk     (lnk.chan)
	);

	assign lnk.trig_sel    = tsel_q;
	assign lnk.chan_code   = chs_q;
	assign lnk.ext_clk_sel = ext_clk_sel;

	////////////////////////////////////////////////////////////////////////////
	// Decode and conditions
	assign wr_ctrl0   = reg_wr && (reg_addr == OFS_CTRL0);
	assign wr_ctrl1   = reg_wr && (reg_addr == OFS_CTRL1);
	assign wr_trig    = reg_wr && (reg_addr == OFS_TRIG);
	assign wr_stat    = reg_wr && (reg_addr == OFS_STAT);
	assign rc_clk     = (cs_q & CS_RC_MASK) == CS_RC_MASK;
	assign sleep_kill = sleep_active && !rc_clk;

	// Go is honoured only once the enable was already set, never in the same write
	assign go_req = on_q && (state_q == ST_IDLE) &&
	                ((wr_ctrl0 && reg_wdata[CTRL0_GO_BIT]) ||
	                 (lnk.trig_edge && !sleep_active));

	// Clearing go or enable by software stops a running conversion
	assign cancel = sleep_kill ||
	                (wr_ctrl0 && (!reg_wdata[CTRL0_GO_BIT] || !reg_wdata[CTRL0_ON_BIT]));

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_d  = state_q;
		chs_d    = chs_q;
		on_d     = on_q;
		go_d     = go_q;
		cs_d     = cs_q;
		tsel_d   = tsel_q;
		ie_d     = ie_q;
		soff_d   = soff_q;
		start_d  = 1'b0;
		abort_d  = 1'b0;
		wake_d   = 1'b0;
		done_evt = 1'b0;
		rdata_d  = '0;

		if (wr_ctrl0) begin
			chs_d = reg_wdata[CTRL0_CHS_LSB +: CHS_W];
			on_d  = reg_wdata[CTRL0_ON_BIT];
		end
		if (wr_ctrl1) begin
			cs_d = reg_wdata[CTRL1_CS_LSB +: CS_W];
		end
		if (wr_trig) begin
			tsel_d = reg_wdata[TRIG_W-1:0];
		end
		if (wr_stat) begin
			ie_d = reg_wdata[STAT_IE_BIT];
		end

		case (state_q)
			ST_IDLE: begin
				if (go_req) begin
					go_d = 1'b1;
					if (rc_clk) begin
						state_d = ST_DELAY;
					end else begin
						start_d = 1'b1;
						state_d = ST_CONV;
					end
				end
			end
			ST_DELAY: begin
				// Start is held back one instruction so a sleep can go first
				if (cancel) begin
					go_d    = 1'b0;
					state_d = ST_IDLE;
				end else if (instr_tick) begin
					start_d = 1'b1;
					state_d = ST_CONV;
				end
			end
			ST_CONV: begin
				// New go writes and trigger edges fall through untouched here
				if (cancel) begin
					abort_d = 1'b1;
					go_d    = 1'b0;
					state_d = ST_IDLE;
				end else if (conv_done) begin
					done_evt = 1'b1;
					go_d     = 1'b0;
					state_d  = ST_IDLE;
					if (sleep_active) begin
						if (ie_q) begin
							wake_d = 1'b1;
						end else begin
							soff_d = 1'b1;
						end
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase

		// Power-down in sleep leaves the enable bit untouched
		if (sleep_kill) begin
			soff_d = 1'b1;
		end else if (!sleep_active) begin
			soff_d = 1'b0;
		end

		// Read data, valid only in the cycle after the strobe
		if (reg_rd) begin
			if (reg_addr == OFS_CTRL0) begin
				rdata_d = {chs_q, go_q, on_q};
			end else if (reg_addr == OFS_CTRL1) begin
				rdata_d[CTRL1_CS_LSB +: CS_W] = cs_q;
			end else if (reg_addr == OFS_TRIG) begin
				rdata_d[TRIG_W-1:0] = tsel_q;
			end else if (reg_addr == OFS_STAT) begin
				rdata_d[STAT_FLAG_BIT] = flag_q;
				rdata_d[STAT_IE_BIT]   = ie_q;
				rdata_d[STAT_PWR_BIT]  = analog_enable;
				rdata_d[STAT_BUSY_BIT] = state_q != ST_IDLE;
				rdata_d[STAT_SOFF_BIT] = soff_q;
			end else begin
				rdata_d = '0;
			end
		end
	end

	// A completion in the clearing cycle keeps the flag set
	assign flag_d = done_evt ||
	                (flag_q && !(wr_stat && reg_wdata[STAT_FLAG_BIT]));

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			chs_q   <= RST_CTRL0[CTRL0_CHS_LSB +: CHS_W];
			on_q    <= RST_CTRL0[CTRL0_ON_BIT];
			go_q    <= RST_CTRL0[CTRL0_GO_BIT];
			cs_q    <= RST_CTRL1[CTRL1_CS_LSB +: CS_W];
			tsel_q  <= RST_TRIG[TRIG_W-1:0];
			flag_q  <= RST_STAT[STAT_FLAG_BIT];
			ie_q    <= RST_STAT[STAT_IE_BIT];
			soff_q  <= RST_STAT[STAT_SOFF_BIT];
			start_q <= 1'b0;
			abort_q <= 1'b0;
			wake_q  <= 1'b0;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			chs_q   <= chs_d;
			on_q    <= on_d;
			go_q    <= go_d;
			cs_q    <= cs_d;
			tsel_q  <= tsel_d;
			flag_q  <= flag_d;
			ie_q    <= ie_d;
			soff_q  <= soff_d;
			start_q <= start_d;
			abort_q <= abort_d;
			wake_q  <= wake_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata     = rdata_q;
	assign conv_start    = start_q;
	assign conv_abort    = abort_q;
	assign wake_request  = wake_q;
	assign analog_enable = on_q && !soff_q;
	assign chan_src      = lnk.chan_src;
	assign chan_port     = lnk.chan_port;
	assign chan_pin      = lnk.chan_pin;

endmodule : aseq_top

// File: dv/aseq_assertions.sv
// Port-level assertions of the conversion sequencer
module aseq_assertions
	import aseq_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst,
	// Register port
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Core status
	input wire logic              sleep_active,
	input wire logic              ext_clk_sel,
	input wire logic              wake_request,
	// Analog converter
	input wire logic              conv_done,
	input wire logic              conv_start,
	input wire logic              conv_abort,
	input wire logic              analog_enable,
	input wire aseq_src_t         chan_src,
	input wire logic [PORT_W-1:0] chan_port,
	input wire logic [PIN_W-1:0]  chan_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////
	// A start followed by four quiet cycles: a restart in the fourth of them is illegal
	sequence s_run;
		conv_start ##1 (!conv_done && !conv_abort) [*4];
	endsequence
	property p_busy;
		s_run |-> !conv_start;
	endproperty
	a_busy: assert property (p_busy) else $error("start during conversion");
	property p_rd;
		reg_rdata != 8'h00 |-> $past(reg_rd);
	endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
	property p_wake;
		wake_request |-> $past(conv_done) && $past(sleep_active);
	endproperty
	a_wake: assert property (p_wake) else $error("wake without done in sleep");
	property p_abort;
		conv_abort |-> $past(sleep_active) || $past(reg_wr);
	endproperty
	a_abort: assert property (p_abort) else $error("abort without cause");
	property p_start;
		conv_start |-> $past(analog_enable);
	endproperty
	a_start: assert property (p_start) else $error("start while powered down");
	property p_fall;
		$fell(analog_enable) |-> $past(reg_wr) || $past(sleep_active);
	endproperty
	a_fall: assert property (p_fall) else $error("power lost without cause");
	property p_none;
		chan_src != SRC_PIN |-> chan_port == 3'h0 && chan_pin == 3'h0;
	endproperty
	a_none: assert property (p_none) else $error("pin fields without pin");
	property p_port;
		chan_src == SRC_PIN |-> chan_port <= 3'h5 && !(chan_port == 3'h4 && chan_pin > 3'h2);
	endproperty
	a_port: assert property (p_port) else $error("pin outside map");
	property p_a67;
		$past(ext_clk_sel) && ext_clk_sel |->
			!(chan_src == SRC_PIN && chan_port == 3'h0 && chan_pin[2:1] == 2'b11);
	endproperty
	a_a67: assert property (p_a67) else $error("pin six or seven with ext clock");

endmodule : aseq_assertions

// File: dv/tb_top.sv
// Self-checking testbench of the conversion sequencer
module tb_top
	import aseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  sys_clk, rst, reg_wr, reg_rd, sleep_active;
	logic                  instr_tick, ext_clk_sel, conv_done;
	logic                  wake_request, conv_start, conv_abort, analog_enable;
	logic [ADDR_W-1:0]     reg_addr;
	logic [DATA_W-1:0]     reg_wdata, reg_rdata;
	logic [PORT_W-1:0]     chan_port;
	logic [PIN_W-1:0]      chan_pin;
	logic [TRIG_SRC_N-1:0] trig_src;
	aseq_src_t             chan_src;
	int                    fail_count = 0;
	int                    n_checks = 0;

	aseq_top i_aseq_top (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sleep_active(sleep_active), .instr_tick(instr_tick), .ext_clk_sel(ext_clk_sel),
		.wake_request(wake_request), .conv_done(conv_done), .conv_start(conv_start),
		.conv_abort(conv_abort), .analog_enable(analog_enable), .chan_src(chan_src),
		.chan_port(chan_port), .chan_pin(chan_pin), .trig_src(trig_src)
	);

	////////////////////////////////
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk({1'b0, reg_rdata}, {1'b0, exp});
	endtask : rd

	task automatic pulse(input bit tick);
		@(posedge sys_clk);
		if (tick) instr_tick <= 1'b1;
		else conv_done <= 1'b1;
		@(posedge sys_clk);
		instr_tick <= 1'b0;
		conv_done  <= 1'b0;
	endtask : pulse

	// Cycle of the start pulse, counting the call's own cycle as 1; 0 when none comes within eight
	task automatic go_wait(input int exp);
		int n = 0;
		for (int i = 1; i <= 8 && n == 0; i++) begin
			#1 if (conv_start === 1'b1) n = i;
			@(posedge sys_clk);
		end
		chk(9'(n), 9'(exp));
	endtask : go_wait

	function automatic logic [8:0] exp_ch(input logic [5:0] c, input logic x);
		case (c)
			CH_GND:  return {SRC_GND, 6'h00};
			CH_TEMP: return {SRC_TEMP, 6'h00};
			CH_DAC:  return {SRC_DAC, 6'h00};
			CH_REF1: return {SRC_REF1, 6'h00};
			CH_REF2: return {SRC_REF2, 6'h00};
			default: ;
		endcase
		if ((c <= CH_E_LAST || (c >= CH_F_BASE && c <= CH_F_LAST)) && !(x && c[5:1] == 5'h03))
			return {SRC_PIN, c};
		return {SRC_NONE, 6'h00};
	endfunction : exp_ch

	////////////////////////////////
	task automatic t_reset;
		for (int a = 0; a < 5; a++) begin
			rd(4'(a == 4 ? 9 : a), 8'h00);
		end
		wr(OFS_TRIG, 8'hff);
		rd(OFS_TRIG, 8'h1f);
	endtask : t_reset

	task automatic t_chan;
		for (int i = 0; i < 128; i++) begin
			@(posedge sys_clk);
			ext_clk_sel <= i[6];
			wr(OFS_CTRL0, {i[5:0], 2'b00});
			@(posedge sys_clk);
			#1 chk({chan_src, chan_port, chan_pin}, exp_ch(6'(i), i[6]));
		end
		rd(OFS_CTRL0, 8'hfc);
	endtask : t_chan

	task automatic t_soft;
		wr(OFS_CTRL0, 8'h03);
		go_wait(0);
		wr(OFS_CTRL0, 8'h03);
		go_wait(1);
		wr(OFS_CTRL0, 8'h03);
		go_wait(0);
		rd(OFS_CTRL0, 8'h03);
		pulse(0);
		rd(OFS_CTRL0, 8'h01);
		rd(OFS_STAT, 8'h05);
	endtask : t_soft

	task automatic t_rc_sleep;
		wr(OFS_CTRL1, 8'h30);
		wr(OFS_STAT, 8'h03);
		wr(OFS_CTRL0, 8'h03);
		go_wait(0);
		pulse(1);
		go_wait(1);
		@(posedge sys_clk);
		sleep_active <= 1'b1;
		rd(OFS_CTRL0, 8'h03);
		pulse(0);
		#1 chk(9'(wake_request), 9'h001);
		@(posedge sys_clk);
		sleep_active <= 1'b0;
		wr(OFS_STAT, 8'h01);
		wr(OFS_CTRL0, 8'h03);
		pulse(1);
		go_wait(1);
		@(posedge sys_clk);
		sleep_active <= 1'b1;
		pulse(0);
		#1 chk(9'({wake_request, analog_enable}), 9'h000);
		rd(OFS_CTRL0, 8'h01);
		rd(OFS_STAT, 8'h11);
		@(posedge sys_clk);
		sleep_active <= 1'b0;
	endtask : t_rc_sleep

	task automatic t_abort;
		wr(OFS_CTRL1, 8'h00);
		wr(OFS_CTRL0, 8'h03);
		go_wait(1);
		@(posedge sys_clk);
		sleep_active <= 1'b1;
		@(posedge sys_clk);
		#1 chk(9'({conv_abort, analog_enable}), 9'h002);
		rd(OFS_CTRL0, 8'h01);
		wr(OFS_TRIG, 8'h02);
		@(posedge sys_clk);
		trig_src <= 19'h00004;
		go_wait(0);
		@(posedge sys_clk);
		trig_src     <= '0;
		sleep_active <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk(9'(analog_enable), 9'h001);
	endtask : t_abort

	// Source levels go back low before the next select, else a select write edges
	task automatic t_trig;
		for (int s = 0; s <= 18; s++) begin
			wr(OFS_TRIG, 8'(s));
			@(posedge sys_clk);
			trig_src <= 19'h00001 << s;
			go_wait(s == 0 ? 0 : 3);
			if (s != 0) pulse(0);
			@(posedge sys_clk);
			trig_src <= '0;
		end
	endtask : t_trig

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		#200us;
		fail_count++;
		wrap_up();
	end

	initial begin
		{rst, reg_wr, reg_rd, sleep_active, instr_tick, ext_clk_sel, conv_done} = 7'h40;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		trig_src  = '0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_chan();
		t_soft();
		t_rc_sleep();
		t_abort();
		t_trig();
		wrap_up();
	end

endmodule : tb_top

bind aseq_top aseq_assertions i_aseq_assertions (
	.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sleep_active(sleep_active), .ext_clk_sel(ext_clk_sel), .wake_request(wake_request),
	.conv_done(conv_done), .conv_start(conv_start), .conv_abort(conv_abort),
	.analog_enable(analog_enable), .chan_src(chan_src), .chan_port(chan_port),
	.chan_pin(chan_pin)
);
